// ---- core/usart_ext.sv ----
// Serial transceiver with flow control, smart-card and infrared mode selection
// Overview of operation
// - Mode code 0x2 selects hardware flow control; receive relies on the DMA channel.
// - In flow control, RTS is high while receiver disabled or DMA buffer full.
// - In flow control, RTS falls once the receiver is enabled and the DMA buffer is not full.
// - New DMA buffer clears buffer-full so RTS falls; remote waits on RTS high.
// - CTS high stops transmit after current character; next starts when CTS low.
// - Mode code 0x4 is smart-card T=0, 0x5 is smart-card T=1.
// - Smart-card line is bidirectional, driven only while transmitting or signalling an error; SCK is card clock.
// - Smart-card frame fixed: 8 data bits, even parity, 1 stop (T=1) or guard time (T=0); bit order selectable.
// - T=0 sends start, 8 data, parity, then two undriven guard bit times.
// - T=0 receiver drives line low in guard time on parity error.
// - T=0 parity error: character not loaded, check error flag set.
// - Receive errors counted up to 255; reading the count clears it.
// - NACK inhibit suppresses the error signal and sets a sticky status bit.
// - NACK inhibit stores the faulty character without raising receive ready.
// - Nonzero repeat count retransmits NACKed characters, eight transmissions at most.
// - Repeat limit flag set at repeat count; acknowledged repeat clears the counter.
// - Control write with clear-repeat bit clears the repeat limit flag.
// - NACK limit: after max NACKs accept character, acknowledge, set repeat limit flag.
// - T=1 uses one stop bit, parity generated and checked, mismatch flags error.
// - Mode code 0x8 selects infrared operation, signalled on irda_on_o.
`timescale 1ns/1ps
module usart_ext (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  input  wire logic        rx_buf_full_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             txd_oe_o,
  input  wire logic        cts_i,
  output logic             rts_o,
  output logic             sck_o,
  output logic             irda_on_o
);
  typedef enum logic [2:0] {TX_IDLE, TX_SHIFT, TX_GUARD, TX_NACK} tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_SHIFT, RX_GUARD, RX_SIGNAL} rx_st_t;

  typedef struct packed
  {
    logic [15:0] mode;
    logic [15:0] baud;
    logic        rx_en;
    logic        tx_en;
    logic [7:0]  thr;
    logic        thr_full;
    logic [7:0]  rhr;
    logic        receive_ready_flag;
    logic        check_error_flag;
    logic        iter;
    logic        nack_st;
    logic [7:0]  nerr;
    logic [15:0] rdata;
    tx_st_t      tx_st;
    logic [3:0]  tx_cnt;
    logic [2:0]  tx_rep;
    logic [7:0]  tx_chr;
    logic        txd;
    rx_st_t      rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_nak;
    logic        rx_drive;
  } state_t;

  state_t st_reg;
  state_t st_next;

  bit_tick_if bt ();

  logic [3:0] op_mode;
  logic       smart;
  logic       t0;
  logic [2:0] max_iter;
  logic [7:0] tx_line;
  logic       tx_par;
  logic [7:0] rx_data;
  logic [7:0] rx_raw;
  logic       rx_bad;

  assign op_mode  = st_reg.mode[usart_ext_pkg::MR_MODE_LSB +: 4];
  assign smart    = op_mode == usart_ext_pkg::MODE_T0 || op_mode == usart_ext_pkg::MODE_T1;
  assign t0       = op_mode == usart_ext_pkg::MODE_T0;
  assign max_iter = st_reg.mode[usart_ext_pkg::MR_ITER_LSB +: 3];

  assign bt.div = st_reg.baud;
  assign bt.run = 1'b1;

  baud_divider u_div (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .bt        (bt)
  );

  // Transmit character ordering and parity
  shift_frame u_txf (
    .data_i (st_reg.tx_chr),
    .msb_first_select_i (st_reg.mode[usart_ext_pkg::MR_MSB_FIRST_SELECT_BIT]),
    .line_o (tx_line),
    .par_o  (tx_par)
  );

  // Received bits are in line order; undo msb-first ordering
  assign rx_raw = st_reg.rx_sh[7:0];
  shift_frame u_rxf (
    .data_i (rx_raw),
    .msb_first_select_i (st_reg.mode[usart_ext_pkg::MR_MSB_FIRST_SELECT_BIT]),
    .line_o (rx_data),
    .par_o  ()
  );
  assign rx_bad = (^rx_raw) != st_reg.rx_sh[8];

  // Saturating error count
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == usart_ext_pkg::NERR_MAX) ? v : v + 8'h01;
  endfunction

  // Register bus, transmitter and receiver next state
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = 16'h0000;
    // Register writes
    if (wr_i)
    begin
      case (addr_i)
        usart_ext_pkg::CTRL_OFS:
        begin
          if (wdata_i[usart_ext_pkg::CR_RXEN_BIT])  st_next.rx_en = 1'b1;
          if (wdata_i[usart_ext_pkg::CR_RXDIS_BIT]) st_next.rx_en = 1'b0;
          if (wdata_i[usart_ext_pkg::CR_TXEN_BIT])  st_next.tx_en = 1'b1;
          if (wdata_i[usart_ext_pkg::CR_TXDIS_BIT]) st_next.tx_en = 1'b0;
          if (wdata_i[usart_ext_pkg::CR_RSTA_BIT])  st_next.check_error_flag = 1'b0;
          if (wdata_i[usart_ext_pkg::CR_CLEAR_REPEAT_FLAG_CMD_BIT])  st_next.iter = 1'b0;
          if (wdata_i[usart_ext_pkg::CR_RNAK_BIT])  st_next.nack_st = 1'b0;
        end
        usart_ext_pkg::MODE_OFS: st_next.mode = wdata_i;
        usart_ext_pkg::BAUD_OFS: st_next.baud = wdata_i;
        usart_ext_pkg::TXHR_OFS:
        begin
          st_next.thr      = wdata_i[7:0];
          st_next.thr_full = 1'b1;
        end
        default: ;
      endcase
    end
    // Register reads, data valid in the next cycle
    if (rd_i)
    begin
      case (addr_i)
        usart_ext_pkg::MODE_OFS: st_next.rdata = st_reg.mode;
        usart_ext_pkg::BAUD_OFS: st_next.rdata = st_reg.baud;
        usart_ext_pkg::STAT_OFS:
        begin
          st_next.rdata[usart_ext_pkg::SR_RECEIVE_READY_FLAG_BIT] = st_reg.receive_ready_flag;
          st_next.rdata[usart_ext_pkg::SR_TXRDY_BIT] = ~st_reg.thr_full;
          st_next.rdata[usart_ext_pkg::SR_CHECK_ERROR_FLAG_BIT]  = st_reg.check_error_flag;
          st_next.rdata[usart_ext_pkg::SR_ITER_BIT]  = st_reg.iter;
          st_next.rdata[usart_ext_pkg::SR_NACK_BIT]  = st_reg.nack_st;
          st_next.rdata[usart_ext_pkg::SR_TXEMP_BIT] =
            ~st_reg.thr_full && st_reg.tx_st == TX_IDLE;
          st_next.rdata[usart_ext_pkg::SR_RXEN_BIT]  = st_reg.rx_en;
          st_next.rdata[usart_ext_pkg::SR_TXEN_BIT]  = st_reg.tx_en;
        end
        usart_ext_pkg::RXHR_OFS:
        begin
          st_next.rdata = {8'h00, st_reg.rhr};
          st_next.receive_ready_flag = 1'b0;
        end
        usart_ext_pkg::NERR_OFS:
        begin
          st_next.rdata = {8'h00, st_reg.nerr};
          st_next.nerr  = 8'h00;
        end
        default: st_next.rdata = 16'h0000;
      endcase
    end

    // Transmitter
    case (st_reg.tx_st)
      TX_IDLE:
      begin
        st_next.txd = 1'b1;
        // Flow control holds the next start while CTS is high
        if (bt.tick && st_reg.tx_en && st_reg.thr_full &&
            !(op_mode == usart_ext_pkg::MODE_HSHAKE && cts_i))
        begin
          st_next.tx_chr   = st_reg.thr;
          st_next.thr_full = 1'b0;
          st_next.tx_rep   = 3'h0;
          st_next.tx_st    = TX_SHIFT;
          st_next.tx_cnt   = 4'h0;
          st_next.txd      = 1'b0;
        end
      end
      TX_SHIFT:
      begin
        if (bt.tick)
        begin
          st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
          if (st_reg.tx_cnt < 4'(usart_ext_pkg::DATA_BITS))
            st_next.txd = tx_line[st_reg.tx_cnt[2:0]];
          else if (st_reg.tx_cnt == 4'(usart_ext_pkg::DATA_BITS))
            st_next.txd = smart ? tx_par : 1'b1;
          else
          begin
            st_next.txd    = 1'b1;
            st_next.tx_cnt = 4'h0;
            st_next.tx_st  = TX_GUARD;
          end
        end
      end
      TX_GUARD:
      begin
        // Guard or stop bits; line released in T=0
        if (bt.half && t0 && st_reg.tx_cnt == 4'h0 && !rxd_i)
          st_next.tx_st = TX_NACK;
        else if (bt.tick)
        begin
          st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
          if (st_reg.tx_cnt + 4'h1 >= (t0 ? 4'(usart_ext_pkg::GUARD_BITS - 1) :
              (st_reg.mode[usart_ext_pkg::MR_STOP2_BIT] && op_mode != usart_ext_pkg::MODE_T1
               ? 4'h1 : 4'h0)))
          begin
            st_next.tx_st  = TX_IDLE;
            st_next.tx_rep = 3'h0;
          end
        end
      end
      TX_NACK:
      begin
        // Error bit plus full guard time, then repeat if allowed
        if (bt.tick)
        begin
          st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
          if (st_reg.tx_cnt == 4'(usart_ext_pkg::GUARD_BITS))
          begin
            if (max_iter != 3'h0 && st_reg.tx_rep != max_iter)
            begin
              st_next.tx_rep = st_reg.tx_rep + 3'h1;
              if (st_reg.tx_rep + 3'h1 == max_iter)
                st_next.iter = 1'b1;
              st_next.tx_st  = TX_SHIFT;
              st_next.tx_cnt = 4'h0;
              st_next.txd    = 1'b0;
            end
            else
              st_next.tx_st = TX_IDLE;
          end
        end
      end
      default: st_next.tx_st = TX_IDLE;
    endcase

    // Receiver
    case (st_reg.rx_st)
      RX_IDLE:
      begin
        st_next.rx_drive = 1'b0;
        if (st_reg.rx_en && bt.half && !rxd_i)
        begin
          st_next.rx_st  = RX_SHIFT;
          st_next.rx_cnt = 4'h0;
        end
      end
      RX_SHIFT:
      begin
        if (bt.half)
        begin
          st_next.rx_sh  = {rxd_i, st_reg.rx_sh[8:1]};
          st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
          if (st_reg.rx_cnt == 4'(usart_ext_pkg::DATA_BITS))
            st_next.rx_st = RX_GUARD;
        end
      end
      RX_GUARD:
      begin
        // Decide mid first guard bit, so an error bit stays inside the guard
        if (bt.half)
        begin
          st_next.rx_st = RX_IDLE;
          if (!smart || !rx_bad)
          begin
            st_next.rhr    = rx_data;
            st_next.receive_ready_flag  = 1'b1;
            st_next.rx_nak = 3'h0;
          end
          else if (!t0)
          begin
            st_next.rhr  = rx_data;
            st_next.receive_ready_flag = 1'b1;
            st_next.check_error_flag = 1'b1;
            st_next.nerr = sat_inc(st_next.nerr);
          end
          else if (st_reg.mode[usart_ext_pkg::MR_NACK_INHIBIT_BIT])
          begin
            st_next.rhr     = rx_data;
            st_next.nack_st = 1'b1;
            st_next.nerr    = sat_inc(st_next.nerr);
          end
          else if (st_reg.mode[usart_ext_pkg::MR_DSNK_BIT] && st_reg.rx_nak == max_iter)
          begin
            st_next.rhr    = rx_data;
            st_next.receive_ready_flag  = 1'b1;
            st_next.iter   = 1'b1;
            st_next.rx_nak = 3'h0;
          end
          else
          begin
            st_next.check_error_flag     = 1'b1;
            st_next.nerr     = sat_inc(st_next.nerr);
            st_next.rx_nak   = st_reg.rx_nak + 3'h1;
            st_next.rx_drive = 1'b1;
            st_next.rx_st    = RX_SIGNAL;
          end
        end
      end
      RX_SIGNAL:
      begin
        // Hold the error bit low for one bit time
        if (bt.half)
        begin
          st_next.rx_drive = 1'b0;
          st_next.rx_st    = RX_IDLE;
        end
      end
      default: st_next.rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_reg       <= '0;
      st_reg.mode  <= usart_ext_pkg::MODE_RST;
      st_reg.baud  <= usart_ext_pkg::BAUD_RST;
      st_reg.txd   <= 1'b1;
      st_reg.tx_st <= TX_IDLE;
      st_reg.rx_st <= RX_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // Pin drive: smart-card line driven only while sending or signalling
  assign txd_o    = st_reg.rx_drive ? 1'b0 : st_reg.txd;
  assign txd_oe_o = st_reg.rx_drive || !smart || st_reg.tx_st == TX_SHIFT;

  // Flow-control request to send
  assign rts_o = (op_mode == usart_ext_pkg::MODE_HSHAKE) &&
                 (!st_reg.rx_en || rx_buf_full_i);
  assign sck_o     = smart & bt.sck;
  assign irda_on_o = op_mode == usart_ext_pkg::MODE_IRDA;
  assign rdata_o   = st_reg.rdata;
endmodule

// ---- core/usart_ext_pkg.sv ----
// Constants shared by the serial transceiver mode extensions
package usart_ext_pkg;
  // Register offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] MODE_OFS = 4'h1;
  localparam logic [3:0] STAT_OFS = 4'h2;
  localparam logic [3:0] TXHR_OFS = 4'h3;
  localparam logic [3:0] RXHR_OFS = 4'h4;
  localparam logic [3:0] NERR_OFS = 4'h5;
  localparam logic [3:0] BAUD_OFS = 4'h6;
  // Operating mode codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_HSHAKE = 4'h2;
  localparam logic [3:0] MODE_T0     = 4'h4;
  localparam logic [3:0] MODE_T1     = 4'h5;
  localparam logic [3:0] MODE_IRDA   = 4'h8;
  // Mode register fields
  localparam int MR_MODE_LSB  = 0;
  localparam int MR_MSB_FIRST_SELECT_BIT  = 4;
  localparam int MR_STOP2_BIT = 5;
  localparam int MR_NACK_INHIBIT_BIT = 6;
  localparam int MR_DSNK_BIT  = 7;
  localparam int MR_ITER_LSB  = 8;
  // Control register bits
  localparam int CR_RXEN_BIT  = 0;
  localparam int CR_RXDIS_BIT = 1;
  localparam int CR_TXEN_BIT  = 2;
  localparam int CR_TXDIS_BIT = 3;
  localparam int CR_RSTA_BIT  = 4;
  localparam int CR_CLEAR_REPEAT_FLAG_CMD_BIT  = 5;
  localparam int CR_RNAK_BIT  = 6;
  // Status register bits
  localparam int SR_RECEIVE_READY_FLAG_BIT = 0;
  localparam int SR_TXRDY_BIT = 1;
  localparam int SR_CHECK_ERROR_FLAG_BIT  = 2;
  localparam int SR_ITER_BIT  = 3;
  localparam int SR_NACK_BIT  = 4;
  localparam int SR_TXEMP_BIT = 5;
  localparam int SR_RXEN_BIT  = 6;
  localparam int SR_TXEN_BIT  = 7;
  // Reset values and counts
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] BAUD_RST = 16'h0004;
  localparam logic [7:0]  NERR_MAX = 8'hff;
  localparam int          DATA_BITS = 8;
  localparam int          GUARD_BITS = 2;
endpackage

// ---- core/bit_tick_if.sv ----
// Bit-rate enable and card clock shared between the top and the divider
`timescale 1ns/1ps
interface bit_tick_if;
  logic [15:0] div;
  logic        run;
  logic        tick;
  logic        half;
  logic        sck;
  modport gen (input div, input run, output tick, output half, output sck);
  modport use_ (output div, output run, input tick, input half, input sck);
endinterface

// ---- core/baud_divider.sv ----
// Bit-rate divider producing bit and mid-bit enables and the card clock
`timescale 1ns/1ps
module baud_divider (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  bit_tick_if.gen   bt
);
  typedef struct packed
  {
    logic [15:0] cnt;
    logic        sck;
  } div_state_t;
  div_state_t st_reg;
  div_state_t st_next;

  // Count down once per bit, card clock toggles every mclk cycle, giving mclk/2
  always_comb
  begin
    st_next = st_reg;
    if (!bt.run || st_reg.cnt == 16'h0000)
      st_next.cnt = bt.div;
    else
      st_next.cnt = st_reg.cnt - 16'h0001;
    st_next.sck = ~st_reg.sck;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bt.tick = bt.run && st_reg.cnt == 16'h0000;
  assign bt.half = bt.run && st_reg.cnt == {1'b0, bt.div[15:1]};
  assign bt.sck  = st_reg.sck;
endmodule

// ---- core/shift_frame.sv ----
// Parity and bit-order helper for one eight-bit character
`timescale 1ns/1ps
module shift_frame (
  input  wire logic [7:0] data_i,
  input  wire logic       msb_first_select_i,
  output logic [7:0]      line_o,
  output logic            par_o
);
  // Reverse order for msb-first, even parity over data
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      line_o[i] = msb_first_select_i ? data_i[7 - i] : data_i[i];
    par_o = ^data_i;
  end
endmodule

// ---- tb/usart_ext_props.sv ----
// Checker for the serial transceiver mode extensions
`timescale 1ns/1ps
module usart_ext_props (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        rx_buf_full_i,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        txd_oe_o,
  input wire logic        cts_i,
  input wire logic        rts_o,
  input wire logic        sck_o,
  input wire logic        irda_on_o
);
  localparam int HOLD = 60;
  logic [3:0] mode_m;
  logic       rxen_m;
  logic       txen_m;
  logic [7:0] cts_cnt;
  logic       smart;
  logic       hs;
  assign smart = (mode_m == usart_ext_pkg::MODE_T0) || (mode_m == usart_ext_pkg::MODE_T1);
  assign hs = (mode_m == usart_ext_pkg::MODE_HSHAKE);
  // Mirror of mode, enables and CTS hold time
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      mode_m  <= usart_ext_pkg::MODE_RST[3:0];
      rxen_m  <= 1'b0;
      txen_m  <= 1'b0;
      cts_cnt <= 8'h00;
    end
    else
    begin
      if (wr_i && addr_i == usart_ext_pkg::MODE_OFS)
        mode_m <= wdata_i[3:0];
      if (wr_i && addr_i == usart_ext_pkg::CTRL_OFS)
      begin
        rxen_m <= (rxen_m | wdata_i[0]) & ~wdata_i[1];
        txen_m <= (txen_m | wdata_i[2]) & ~wdata_i[3];
      end
      cts_cnt <= !cts_i ? 8'h00 : cts_cnt + {7'h00, cts_cnt != 8'hff};
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_nerr_rd;
    rd_i && addr_i == usart_ext_pkg::NERR_OFS && rxd_i;
  endsequence
  property p_rts_stop;
    hs && (!rxen_m || rx_buf_full_i) |-> rts_o;
  endproperty
  property p_rts_go;
    hs && rxen_m && !rx_buf_full_i |-> !rts_o;
  endproperty
  property p_cts_hold;
    hs && cts_cnt >= HOLD |-> txd_o;
  endproperty
  property p_oe_idle;
    smart && !txen_m && !rxen_m |-> !txd_oe_o;
  endproperty
  property p_sck_off;
    !smart && !$past(smart) && !$past(smart, 2) |-> !sck_o;
  endproperty
  property p_nerr_clr;
    s_nerr_rd ##1 rxd_i ##1 s_nerr_rd |=> rdata_o[7:0] == 8'h00;
  endproperty
  property p_irda;
    irda_on_o == (mode_m == usart_ext_pkg::MODE_IRDA);
  endproperty
  property p_rd_only;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rts_stop: assert property (p_rts_stop) else $error("rts low while blocked");
  a_rts_go: assert property (p_rts_go) else $error("rts high while open");
  a_cts_hold: assert property (p_cts_hold) else $error("sent while cts high");
  a_oe_idle: assert property (p_oe_idle) else $error("line driven while idle");
  a_sck_off: assert property (p_sck_off) else $error("card clock outside card");
  a_nerr_clr: assert property (p_nerr_clr) else $error("count not cleared");
  a_irda: assert property (p_irda) else $error("infrared select wrong");
  a_rd_only: assert property (p_rd_only) else $error("read data outside slot");
endmodule

// ---- tb/line_partner.sv ----
// Behavioural remote device or smart card on the shared serial line
`timescale 1ns/1ps
module line_partner #(
  parameter int BIT = 5
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic rts_i,
  output logic      drv_o
);
  logic [7:0] got[$];
  int         nack_left = 0;
  int         nacks_seen = 0;
  bit         smart = 1'b0;
  bit         hs = 1'b0;
  bit         busy = 1'b0;
  initial drv_o = 1'b1;
  // Sends one character with even or broken parity, then watches the guard
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    logic       seen;
    f = {(^d) ^ bad, d, 1'b0};
    seen = 1'b0;
    wait (!hs || !rts_i);
    @(posedge clk_i);
    busy = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      drv_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
    drv_o <= 1'b1;
    repeat (3 * BIT)
    begin
      @(posedge clk_i);
      seen |= !line_i;
    end
    nacks_seen += seen;
    busy = 1'b0;
  endtask
  // Collects characters from the block, answering with an error on request
  always
  begin : rx
    logic [8:0] sh;
    @(negedge line_i iff !busy);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge clk_i);
      sh[i] = line_i;
    end
    got.push_back(sh[7:0]);
    if (smart && nack_left > 0)
    begin
      busy = 1'b1;
      repeat (BIT - BIT / 2) @(posedge clk_i);
      drv_o <= 1'b0;
      repeat (BIT) @(posedge clk_i);
      drv_o <= 1'b1;
      @(posedge clk_i);
      nack_left--;
      busy = 1'b0;
    end
  end
endmodule

// ---- tb/usart_ext_tb_top.sv ----
// Testbench for the serial transceiver mode extensions
`timescale 1ns/1ps
`define CHK(nm, ex, ob) begin cmp_count++; if ((ob) !== (ex)) begin err_count++; \
  $display("Error %s exp %h got %h", nm, ex, ob); end end
module usart_ext_tb_top;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        rx_buf_full_i = 1'b0;
  logic        cts_i = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] d;
  logic        txd_o, txd_oe_o, rts_o, sck_o, irda_on_o, pdrv, line;
  int          err_count = 0;
  int          cmp_count = 0;
  int          n;
  // Open-drain line with pull-up
  assign line = (txd_oe_o ? txd_o : 1'b1) & pdrv;
  always #20 mclk_i = ~mclk_i;
  usart_ext dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_buf_full_i(rx_buf_full_i),
    .rxd_i(line), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .cts_i(cts_i), .rts_o(rts_o),
    .sck_o(sck_o), .irda_on_o(irda_on_o));
  line_partner #(.BIT(int'(usart_ext_pkg::BAUD_RST) + 1)) partner (.clk_i(mclk_i),
    .line_i(line), .rts_i(rts_o), .drv_o(pdrv));
  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] a);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
    @(posedge mclk_i);
  endtask
  task automatic ctl(input logic [15:0] v);
    wr(usart_ext_pkg::CTRL_OFS, v);
  endtask
  task automatic mr(input logic [15:0] v);
    wr(usart_ext_pkg::MODE_OFS, v);
  endtask
  task automatic st(input int b, input logic e);
    rd(usart_ext_pkg::STAT_OFS);
    `CHK("status", e, d[b])
  endtask
  task automatic wait_got(input int k);
    for (int i = 0; i < 3000 && partner.got.size() < k; i++)
      @(posedge mclk_i);
    repeat (100) @(posedge mclk_i);
    `CHK("frames", k, partner.got.size())
  endtask
  // Reset values and an unmapped index
  task automatic t_regs;
    rd(usart_ext_pkg::MODE_OFS);
    `CHK("mode", usart_ext_pkg::MODE_RST, d)
    rd(usart_ext_pkg::BAUD_OFS);
    `CHK("baud", usart_ext_pkg::BAUD_RST, d)
    wr(4'h7, 16'hffff);
    rd(4'h7);
    `CHK("unmapped", 16'h0000, d)
  endtask
  // RTS against receiver enable and buffer full
  task automatic t_flow;
    mr(16'h0002);
    `CHK("rts", 1'b1, rts_o)
    ctl(16'h0001);
    `CHK("rts", 1'b0, rts_o)
    rx_buf_full_i <= 1'b1;
    @(posedge mclk_i);
    `CHK("rts", 1'b1, rts_o)
    rx_buf_full_i <= 1'b0;
    @(posedge mclk_i);
    `CHK("rts", 1'b0, rts_o)
    `CHK("irda", 1'b0, irda_on_o)
  endtask
  // CTS holds a waiting character but not one in flight
  task automatic t_cts;
    ctl(16'h0006);
    cts_i <= 1'b1;
    wr(usart_ext_pkg::TXHR_OFS, 16'h003a);
    repeat (150) @(posedge mclk_i);
    `CHK("held", 0, partner.got.size())
    cts_i <= 1'b0;
    wait_got(1);
    wr(usart_ext_pkg::TXHR_OFS, 16'h00c5);
    for (int i = 0; i < 200 && line; i++)
      @(posedge mclk_i);
    cts_i <= 1'b1;
    wait_got(2);
    `CHK("tx", 8'hc5, partner.got[1])
    cts_i <= 1'b0;
  endtask
  // Card transmit with repetition limit and bit order
  task automatic t_t0tx;
    partner.got.delete();
    partner.smart = 1'b1;
    partner.nack_left = 5;
    mr(16'h0204);
    wr(usart_ext_pkg::TXHR_OFS, 16'h00a5);
    wait_got(3);
    `CHK("rep", 8'ha5, partner.got[2])
    st(usart_ext_pkg::SR_ITER_BIT, 1'b1);
    ctl(16'h0020);
    st(usart_ext_pkg::SR_ITER_BIT, 1'b0);
    partner.nack_left = 1;
    wr(usart_ext_pkg::TXHR_OFS, 16'h0001);
    wait_got(5);
    st(usart_ext_pkg::SR_ITER_BIT, 1'b0);
    mr(16'h0014);
    wr(usart_ext_pkg::TXHR_OFS, 16'h0001);
    wait_got(6);
    `CHK("msb_first_select", 8'h80, partner.got[5])
    ctl(16'h0008);
  endtask
  // Card receive: error signal, count, inhibit, limit, saturation
  task automatic t_t0rx;
    mr(16'h0004);
    ctl(16'h0001);
    n = partner.nacks_seen;
    partner.send(8'h3c, 1'b1);
    `CHK("nack", n + 1, partner.nacks_seen)
    st(usart_ext_pkg::SR_CHECK_ERROR_FLAG_BIT, 1'b1);
    st(usart_ext_pkg::SR_RECEIVE_READY_FLAG_BIT, 1'b0);
    rd(usart_ext_pkg::NERR_OFS);
    `CHK("nerr", 8'h01, d[7:0])
    rd(usart_ext_pkg::NERR_OFS);
    `CHK("nerr", 8'h00, d[7:0])
    ctl(16'h0010);
    partner.send(8'h5a, 1'b0);
    rd(usart_ext_pkg::RXHR_OFS);
    `CHK("rhr", 8'h5a, d[7:0])
    mr(16'h0044);
    partner.send(8'h96, 1'b1);
    `CHK("nack", n + 1, partner.nacks_seen)
    st(usart_ext_pkg::SR_NACK_BIT, 1'b1);
    st(usart_ext_pkg::SR_RECEIVE_READY_FLAG_BIT, 1'b0);
    rd(usart_ext_pkg::RXHR_OFS);
    `CHK("rhr", 8'h96, d[7:0])
    ctl(16'h0040);
    st(usart_ext_pkg::SR_NACK_BIT, 1'b0);
    mr(16'h0284);
    repeat (3) partner.send(8'h77, 1'b1);
    `CHK("nack", n + 3, partner.nacks_seen)
    st(usart_ext_pkg::SR_ITER_BIT, 1'b1);
    rd(usart_ext_pkg::RXHR_OFS);
    `CHK("rhr", 8'h77, d[7:0])
    mr(16'h0004);
    rd(usart_ext_pkg::NERR_OFS);
    repeat (256) partner.send(8'h01, 1'b1);
    rd(usart_ext_pkg::NERR_OFS);
    `CHK("nerr", 8'hff, d[7:0])
  endtask
  // Block protocol receive and infrared select
  task automatic t_t1;
    mr(16'h0005);
    @(negedge mclk_i);
    n = int'(sck_o);
    @(negedge mclk_i);
    `CHK("sck", !n[0], sck_o)
    partner.send(8'h81, 1'b0);
    st(usart_ext_pkg::SR_RECEIVE_READY_FLAG_BIT, 1'b1);
    rd(usart_ext_pkg::RXHR_OFS);
    `CHK("inv", 8'h7e, ~d[7:0])
    ctl(16'h0010);
    partner.send(8'h18, 1'b1);
    st(usart_ext_pkg::SR_CHECK_ERROR_FLAG_BIT, 1'b1);
    mr(16'h0008);
    `CHK("irda", 1'b1, irda_on_o)
  endtask
  task automatic end_sim;
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    t_regs;
    t_flow;
    t_cts;
    t_t0tx;
    t_t0rx;
    t_t1;
    end_sim;
  end
  // Watchdog
  initial
  begin
    repeat (90000) @(posedge mclk_i);
    err_count++;
    end_sim;
  end
endmodule
bind usart_ext usart_ext_props props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .rx_buf_full_i(rx_buf_full_i), .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
  .cts_i(cts_i), .rts_o(rts_o), .sck_o(sck_o), .irda_on_o(irda_on_o));
